// ===== hw/afe_mux_sample_sequencer.sv
// multiplexer sequencer, sample ram and register slave
module afe_mux_sample_sequencer (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [15:0] awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [15:0] araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic        crystal_timebase_clock,
    input  wire logic        modulator_bit,
    input  wire logic        ce_pass_start,
    input  wire logic [2:0]  ce_rd_addr,
    output logic [31:0]      ce_rd_data,
    output logic [2:0]       mux_select,
    output logic             mux_active,
    output logic             alt_frame_active,
    output logic             battery_load_enable
);
    decim_if dec ();

    afe_seq_pkg::frame_state_t state_q;
    afe_seq_pkg::input_sel_t   sel_d;
    afe_seq_pkg::input_sel_t   sel_q;
    logic [7:0]  ctrl_q;
    logic [15:0] len_q;
    logic        alt_q;
    logic [7:0]  frame_count_q;
    logic        bat_q;
    logic [31:0] ram_q [afe_seq_pkg::RAM_WORDS];
    logic [31:0] ce_rd_data_q;
    logic        xtal_meta_q;
    logic        xtal_sync_q;
    logic        xtal_prev_q;
    logic        mod_meta_q;
    logic        mod_sync_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        rvalid_q;
    logic [1:0]  rresp_q;
    logic [31:0] rdata_q;
    logic        wr_take;
    logic        rd_take;
    logic        step;

    // two stages on both pins before any use
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            xtal_meta_q <= 1'b0;
            xtal_sync_q <= 1'b0;
            xtal_prev_q <= 1'b0;
            mod_meta_q  <= 1'b0;
            mod_sync_q  <= 1'b0;
        end else begin
            xtal_meta_q <= crystal_timebase_clock;
            xtal_sync_q <= xtal_meta_q;
            xtal_prev_q <= xtal_sync_q;
            mod_meta_q  <= modulator_bit;
            mod_sync_q  <= mod_meta_q;
        end
    end

    // one converter sample per crystal rising edge
    assign dec.tick   = xtal_sync_q && !xtal_prev_q;
    assign dec.bit_in = mod_sync_q;
    assign dec.res22  = ctrl_q[afe_seq_pkg::RES22_BIT];
    assign dec.len    = len_q;
    assign step       = dec.done && (state_q != afe_seq_pkg::ST_IDLE);
    assign dec.start  = ce_pass_start || (step && state_q != afe_seq_pkg::ST_S3);

    decim_filter u_filter (
        .aclk    (aclk),
        .aresetn (aresetn),
        .dec     (dec)
    );

    // a pass start aborts any frame still running
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= afe_seq_pkg::ST_IDLE;
        end else if (ce_pass_start) begin
            state_q <= afe_seq_pkg::ST_S0;
        end else if (step) begin
            case (state_q)
                afe_seq_pkg::ST_S0: state_q <= afe_seq_pkg::ST_S1;
                afe_seq_pkg::ST_S1: state_q <= afe_seq_pkg::ST_S2;
                afe_seq_pkg::ST_S2: state_q <= afe_seq_pkg::ST_S3;
                default:            state_q <= afe_seq_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            alt_q         <= 1'b0;
            frame_count_q <= 8'h00;
        end else if (ce_pass_start) begin
            alt_q         <= ctrl_q[afe_seq_pkg::ALT_REQ_BIT];
            frame_count_q <= frame_count_q + 8'h01;
        end
    end

    always_comb begin
        case (state_q)
            afe_seq_pkg::ST_S1: sel_d = afe_seq_pkg::SEL_VOLTAGE_A;
            afe_seq_pkg::ST_S2: sel_d = alt_q ? afe_seq_pkg::SEL_CELL_VOLTAGE
                                              : afe_seq_pkg::SEL_CURRENT_B;
            afe_seq_pkg::ST_S3: sel_d = afe_seq_pkg::SEL_VOLTAGE_B;
            default:            sel_d = alt_q ? afe_seq_pkg::SEL_DIE_THERMAL
                                              : afe_seq_pkg::SEL_CURRENT_A;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sel_q <= afe_seq_pkg::SEL_CURRENT_A;
            bat_q <= 1'b0;
        end else begin
            sel_q <= sel_d;
            // load only while the cell is actually being converted
            bat_q <= ctrl_q[afe_seq_pkg::BME_BIT] && alt_q
                     && (state_q == afe_seq_pkg::ST_S2);
        end
    end

    // no reset on the sample store: contents are data, not control
    always_ff @(posedge aclk) begin
        if (step) begin
            ram_q[sel_d] <= {1'b0, dec.result, 9'h000};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ce_rd_data_q <= 32'h0;
        end else begin
            ce_rd_data_q <= ram_q[ce_rd_addr];
        end
    end

    // write channels are taken together, one response outstanding
    assign wr_take = awvalid && wvalid && !bvalid_q;
    assign rd_take = arvalid && !rvalid_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= afe_seq_pkg::CTRL_RESET;
            len_q  <= afe_seq_pkg::LEN_RESET;
        end else begin
            // a host write in the same cycle wins over the consume
            if (wr_take && awaddr == afe_seq_pkg::CTRL_OFFSET && wstrb[0]) begin
                ctrl_q <= wdata[7:0];
            end else if (ce_pass_start) begin
                ctrl_q[afe_seq_pkg::ALT_REQ_BIT] <= 1'b0;
            end
            if (wr_take && awaddr == afe_seq_pkg::LEN_OFFSET) begin
                if (wstrb[0]) begin
                    len_q[7:0] <= wdata[7:0];
                end
                if (wstrb[1]) begin
                    len_q[15:8] <= wdata[15:8];
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= afe_seq_pkg::RESP_OKAY;
        end else if (wr_take) begin
            bvalid_q <= 1'b1;
            // ram and status accept writes but keep them out
            if (awaddr == afe_seq_pkg::CTRL_OFFSET || awaddr == afe_seq_pkg::LEN_OFFSET
                || awaddr == afe_seq_pkg::STATUS_OFFSET
                || awaddr[15:5] == afe_seq_pkg::RAM_BASE[15:5]) begin
                bresp_q <= afe_seq_pkg::RESP_OKAY;
            end else begin
                bresp_q <= afe_seq_pkg::RESP_DECERR;
            end
        end else if (bready) begin
            bvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rresp_q  <= afe_seq_pkg::RESP_OKAY;
            rdata_q  <= 32'h0;
        end else if (rd_take) begin
            rvalid_q <= 1'b1;
            rresp_q  <= afe_seq_pkg::RESP_OKAY;
            if (araddr == afe_seq_pkg::CTRL_OFFSET) begin
                rdata_q <= {24'h0, ctrl_q};
            end else if (araddr == afe_seq_pkg::LEN_OFFSET) begin
                rdata_q <= {16'h0, len_q};
            end else if (araddr == afe_seq_pkg::STATUS_OFFSET) begin
                rdata_q <= {frame_count_q, 5'h0, sel_q, 7'h0, alt_q, 3'h0, state_q};
            end else if (araddr[15:5] == afe_seq_pkg::RAM_BASE[15:5]) begin
                rdata_q <= ram_q[araddr[4:2]];
            end else begin
                rdata_q <= 32'h0;
                rresp_q <= afe_seq_pkg::RESP_DECERR;
            end
        end else if (rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign awready             = wr_take;
    assign wready              = wr_take;
    assign bvalid              = bvalid_q;
    assign bresp               = bresp_q;
    assign arready             = rd_take;
    assign rvalid              = rvalid_q;
    assign rresp               = rresp_q;
    assign rdata               = rdata_q;
    assign ce_rd_data          = ce_rd_data_q;
    assign mux_select          = sel_q;
    assign mux_active          = state_q != afe_seq_pkg::ST_IDLE;
    assign alt_frame_active    = alt_q;
    assign battery_load_enable = bat_q;

    sequence pass_begin;
        ce_pass_start;
    endsequence

    sequence first_state;
        state_q == afe_seq_pkg::ST_S0;
    endsequence

    frame_launch_a: assert property (@(posedge aclk) disable iff (!aresetn)
        pass_begin |=> first_state)
        else $error("frame did not restart on pass start");

    regular_select_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_q == afe_seq_pkg::ST_S2 && !alt_q) |=> sel_q == afe_seq_pkg::SEL_CURRENT_B)
        else $error("regular frame state 2 did not pick current b");

    alternate_select_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_q == afe_seq_pkg::ST_S0 && alt_q) |=> sel_q == afe_seq_pkg::SEL_DIE_THERMAL)
        else $error("alternate frame state 0 did not pick die thermal");

    voltage_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_q == afe_seq_pkg::ST_S1) |=> sel_q == afe_seq_pkg::SEL_VOLTAGE_A)
        else $error("voltage a replaced in state 1");

    battery_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
        battery_load_enable |-> $past(ctrl_q[afe_seq_pkg::BME_BIT]) && $past(alt_q))
        else $error("battery loaded without enable");

    state_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (!dec.done && !ce_pass_start) |=> $stable(state_q))
        else $error("state changed before its samples were done");

    sample_store_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (step && state_q == afe_seq_pkg::ST_S1)
        |=> ram_q[1] == {1'b0, $past(dec.result), 9'h000})
        else $error("voltage a sample not stored shifted");

    alt_latch_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !ce_pass_start |=> $stable(alt_q))
        else $error("alternate selection changed mid frame");

    regular_first_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_q == afe_seq_pkg::ST_S0 && !alt_q) |=> sel_q == afe_seq_pkg::SEL_CURRENT_A)
        else $error("regular frame state 0 did not pick current a");

    alternate_cell_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_q == afe_seq_pkg::ST_S2 && alt_q) |=> sel_q == afe_seq_pkg::SEL_CELL_VOLTAGE)
        else $error("alternate frame state 2 did not pick cell voltage");

    host_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (rd_take && araddr == afe_seq_pkg::RAM_BASE) |=> rdata == $past(ram_q[0]))
        else $error("host read of sample word 0 wrong");
endmodule : afe_mux_sample_sequencer

// ===== hw/afe_seq_pkg.sv
// constants and types shared by the multiplexer sample sequencer
package afe_seq_pkg;
    localparam logic [15:0] CTRL_OFFSET   = 16'h2020;
    localparam logic [15:0] LEN_OFFSET    = 16'h2024;
    localparam logic [15:0] STATUS_OFFSET = 16'h2028;
    localparam logic [15:0] RAM_BASE      = 16'h2100;
    localparam int          RAM_WORDS     = 8;
    localparam int          ALT_REQ_BIT   = 0;
    localparam int          RES22_BIT     = 1;
    localparam int          BME_BIT       = 6;
    localparam logic [7:0]  CTRL_RESET    = 8'h00;
    localparam logic [15:0] LEN_RESET     = 16'h0040;
    localparam int          RES_NARROW    = 21;
    localparam int          RES_WIDE      = 22;
    localparam int          RESULT_SHIFT  = 9;
    localparam int          CRYSTAL_HZ    = 32768;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_DECERR   = 2'h3;

    // value doubles as the sample ram word index
    typedef enum logic [2:0] {
        SEL_CURRENT_A    = 3'h0,
        SEL_VOLTAGE_A    = 3'h1,
        SEL_CURRENT_B    = 3'h2,
        SEL_VOLTAGE_B    = 3'h3,
        SEL_DIE_THERMAL  = 3'h4,
        SEL_CELL_VOLTAGE = 3'h5
    } input_sel_t;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_S0   = 5'h02,
        ST_S1   = 5'h04,
        ST_S2   = 5'h08,
        ST_S3   = 5'h10
    } frame_state_t;
endpackage : afe_seq_pkg

// ===== hw/decim_if.sv
// link between the sequencer and its decimation filter
interface decim_if;
    logic        start;
    logic        tick;
    logic        bit_in;
    logic        res22;
    logic [15:0] len;
    logic [21:0] result;
    logic        done;

    modport seq  (output start, output tick, output bit_in, output res22, output len,
                  input result, input done);
    modport filt (input start, input tick, input bit_in, input res22, input len,
                  output result, output done);
endinterface : decim_if

// ===== hw/decim_filter.sv
// decimation filter: integrates modulator bits over one multiplexer state
module decim_filter (
    input  wire logic aclk,
    input  wire logic aresetn,
    decim_if.filt     dec
);
    logic [21:0] acc_q;
    logic [15:0] count_q;
    logic        busy_q;
    logic        done_q;
    logic [21:0] result_q;
    logic [21:0] sum;
    logic [15:0] len_eff;
    logic        last;

    assign sum     = acc_q + {21'h0, dec.bit_in};
    assign len_eff = (dec.len == 16'h0) ? 16'h1 : dec.len;
    assign last    = (count_q + 16'h1) == len_eff;

    always_ff @(posedge aclk) begin
        if (!aresetn || dec.start) begin
            acc_q   <= 22'h0;
            count_q <= 16'h0;
        end else if (dec.tick && busy_q) begin
            acc_q   <= sum;
            count_q <= count_q + 16'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            busy_q <= 1'b0;
        end else if (dec.start) begin
            busy_q <= 1'b1;
        end else if (dec.tick && last) begin
            busy_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            done_q   <= 1'b0;
            result_q <= 22'h0;
        end else begin
            done_q <= busy_q && !dec.start && dec.tick && last;
            if (busy_q && !dec.start && dec.tick && last) begin
                // narrow mode drops the top bit
                result_q <= dec.res22 ? sum : {1'b0, sum[20:0]};
            end
        end
    end

    assign dec.done   = done_q;
    assign dec.result = result_q;

    res_width_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (done_q && !$past(dec.res22)) |-> result_q[21] == 1'b0)
        else $error("narrow result exceeds 21 bits");
endmodule : decim_filter

// ===== verif/ce_model.sv
// stand-in for the compute engine and the front end pins around the sequencer
module ce_model (
    output logic             crystal_timebase_clock,
    output logic             modulator_bit,
    output logic             ce_pass_start,
    output logic [2:0]       ce_rd_addr,
    input  wire logic        aclk,
    input  wire logic [31:0] ce_rd_data
);
    timeunit 1ns;
    timeprecision 1ns;

    // crystal runs free, so tick phase against a frame start is arbitrary
    initial begin
        crystal_timebase_clock = 1'b0;
        modulator_bit = 1'b1;
        ce_pass_start = 1'b0;
        ce_rd_addr = 3'h0;
    end

    always #15259 crystal_timebase_clock = ~crystal_timebase_clock;

    // one-cycle pulse at the head of each program pass
    task automatic pass_start();
        @(posedge aclk);
        ce_pass_start <= 1'b1;
        @(posedge aclk);
        ce_pass_start <= 1'b0;
    endtask : pass_start

    // read port answers one cycle after the index is presented
    task automatic read_word(input logic [2:0] i, output logic [31:0] d);
        ce_rd_addr <= i;
        repeat (2) @(posedge aclk);
        d = ce_rd_data;
    endtask : read_word

    // current words skipped by an alternate frame are read back only for current a;
    // the engine keeps its previous values in their place
endmodule : ce_model

// ===== verif/afe_mux_sample_sequencer_tb_top.sv
// self-checking bench for the multiplexer sample sequencer
module afe_mux_sample_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, mux_active, alt_act, bat_en;
    logic        xtal, mbit, pstart;
    logic [15:0] awaddr, araddr;
    logic [31:0] wdata, rdata, ce_data, rd;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rs;
    logic [2:0]  ce_addr, mux_sel;
    int          n_errors;
    int          check_count;

    // every state sees len ticks of ones, so each stored word is len shifted
    localparam logic [31:0] LEN_VAL  = 32'h2;
    localparam logic [31:0] EXP_WORD = LEN_VAL << afe_seq_pkg::RESULT_SHIFT;
    localparam logic [31:0] OKAY     = {30'h0, afe_seq_pkg::RESP_OKAY};
    // status after each frame: count, select, alternate flag, one-hot idle
    localparam logic [31:0] STAT_REG = {8'h01, 15'h0, 1'b0, 3'h0, afe_seq_pkg::ST_IDLE};
    localparam logic [31:0] STAT_ALT = {8'h02, 5'h0, afe_seq_pkg::SEL_DIE_THERMAL, 7'h0,
                                        1'b1, 3'h0, afe_seq_pkg::ST_IDLE};

    afe_mux_sample_sequencer DUT (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .crystal_timebase_clock(xtal), .modulator_bit(mbit), .ce_pass_start(pstart),
        .ce_rd_addr(ce_addr), .ce_rd_data(ce_data), .mux_select(mux_sel),
        .mux_active(mux_active), .alt_frame_active(alt_act), .battery_load_enable(bat_en)
    );

    ce_model cem (
        .crystal_timebase_clock(xtal), .modulator_bit(mbit), .ce_pass_start(pstart),
        .ce_rd_addr(ce_addr), .aclk(aclk), .ce_rd_data(ce_data)
    );

    always #25 aclk = ~aclk;

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic close_out();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out

    // address and data offered together, bready held until the answer
    task automatic axi_wr(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
        // idle edge first, so back-to-back calls never drive a signal twice in one step
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do @(posedge aclk); while (awready !== 1'b1);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do @(posedge aclk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : axi_rd

    task automatic t_reset_values();
        axi_rd(afe_seq_pkg::CTRL_OFFSET, rd, rs);
        chk("ctrl reset", {24'h0, afe_seq_pkg::CTRL_RESET}, rd);
        axi_rd(afe_seq_pkg::LEN_OFFSET, rd, rs);
        chk("len reset", {16'h0, afe_seq_pkg::LEN_RESET}, rd);
        axi_rd(16'h2030, rd, rs);
        chk("unmapped read resp", {30'h0, afe_seq_pkg::RESP_DECERR}, {30'h0, rs});
        chk("unmapped read data", 32'h0, rd);
        axi_wr(16'h2030, 32'h1, rs);
        chk("unmapped write resp", {30'h0, afe_seq_pkg::RESP_DECERR}, {30'h0, rs});
    endtask : t_reset_values

    // runs one frame; optionally raises the alternate request part way through
    task automatic run_frame(input logic [11:0] e_seq, input logic e_alt, input logic e_bat,
                             input logic mid);
        logic [11:0] seq;
        logic [2:0]  last;
        logic        bat;
        logic        alt;
        int          n;
        int          s0;
        seq = 12'h0;
        last = 3'h7;
        bat = 1'b0;
        alt = 1'b0;
        n = 0;
        s0 = 0;
        cem.pass_start();
        // select output lags the state by a cycle
        repeat (2) @(posedge aclk);
        while (mux_active === 1'b1) begin
            if (mux_sel !== last) begin
                seq = {seq[8:0], mux_sel};
                last = mux_sel;
                n++;
            end
            bat = bat | bat_en;
            if (n == 1) begin
                s0++;
                alt = alt_act;
            end
            if (n == 2 && mid) begin
                mid = 1'b0;
                axi_wr(afe_seq_pkg::CTRL_OFFSET, 32'h41, rs);
            end
            @(posedge aclk);
        end
        chk("select order", {20'h0, e_seq}, {20'h0, seq});
        chk("state count", 32'h4, 32'(n));
        chk("alternate flag", {31'h0, e_alt}, {31'h0, alt});
        chk("battery load", {31'h0, e_bat}, {31'h0, bat});
        // first state spans len crystal ticks, tick phase unknown
        chk("state length", 32'h1, {31'h0, s0 >= 600 && s0 <= 1240});
    endtask : run_frame

    task automatic t_frames();
        axi_wr(afe_seq_pkg::LEN_OFFSET, LEN_VAL, rs);
        chk("len write resp", OKAY, {30'h0, rs});
        axi_wr(afe_seq_pkg::CTRL_OFFSET, 32'h40, rs);
        run_frame(12'b000_001_010_011, 1'b0, 1'b0, 1'b1);
        for (int i = 0; i < 4; i++) begin
            cem.read_word(3'(i), rd);
            chk("engine ram word", EXP_WORD, rd);
        end
        axi_rd(afe_seq_pkg::RAM_BASE, rd, rs);
        chk("host ram word 0", EXP_WORD, rd);
        axi_rd(afe_seq_pkg::STATUS_OFFSET, rd, rs);
        chk("status frame 1", STAT_REG, rd);
        run_frame(12'b100_001_101_011, 1'b1, 1'b1, 1'b0);
        axi_rd(afe_seq_pkg::RAM_BASE + 16'h14, rd, rs);
        chk("host ram word", EXP_WORD, rd);
        axi_rd(afe_seq_pkg::CTRL_OFFSET, rd, rs);
        chk("request cleared", 32'h40, rd);
        axi_rd(afe_seq_pkg::STATUS_OFFSET, rd, rs);
        chk("status frame 2", STAT_ALT, rd);
        // skipped current word still holds the last regular sample for the engine
        cem.read_word(3'h0, rd);
        chk("engine keeps current a", EXP_WORD, rd);
        // alternate frames kept rare: only two in the whole run
        axi_wr(afe_seq_pkg::CTRL_OFFSET, 32'h03, rs);
        run_frame(12'b100_001_101_011, 1'b1, 1'b0, 1'b0);
        axi_rd(afe_seq_pkg::RAM_BASE + 16'h10, rd, rs);
        chk("thermal word", EXP_WORD, rd);
    endtask : t_frames

    initial begin
        n_errors = 0;
        check_count = 0;
        aclk = 1'b0;
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        awaddr = 16'h0;
        araddr = 16'h0;
        wdata = 32'h0;
        wstrb = 4'hf;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset_values();
        t_frames();
        close_out();
    end

    // three short frames take about 15k cycles
    initial begin
        repeat (60000) @(posedge aclk);
        n_errors++;
        close_out();
    end
endmodule : afe_mux_sample_sequencer_tb_top
